// >>> hw/scsf_pkg.sv
// Constants, register map and state types for the smart card status flags block
//
// Operation
// - A parity mismatch on a received character sets the parity fault flag at status bit 3.
// - A character with a parity fault is still loaded into the receive data holder but does not set the receive-full flag.
// - While the parity fault flag is 1 no further reception is started or accepted.
// - In clocked synchronous operation a set parity fault flag also halts further transmission.
// - The parity fault flag clears only on a write of 0 that follows a read returning 1.
// - Clearing the receive enable bit leaves the parity fault flag as it was.
// - The transmit done flag at status bit 2 resets to 1 and is set while transmit enable and error signal seen are both 0.
// - With no error signal and an empty transmit holder, transmit done sets 2.5, 1.5 or 1.0 etu after transmit start; in card mode only, else at frame end.
// - The transmit done flag clears on a write of 0 that follows a read returning 1.
// - The transmit done flag also clears when a transfer controller writes the next character into the transmit holder.
// - The received multiprocessor bit at status bit 1 is read-only, resets to 0 and has no function here.
// - For clearable flags only a written 0 has effect, used to clear; a written 1 leaves the flag unchanged.
// - Error signal seen is set when a low error signal from the card is sampled in the guard period.
// - The card mode select bit picks smart card operation when 1 and normal operation when 0.
package scsf_pkg;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STATUS  = 8'h00;
	localparam logic [7:0] ADDR_CONTROL = 8'h04;
	localparam logic [7:0] ADDR_IRQSTAT = 8'h08;
	localparam logic [7:0] ADDR_IRQMASK = 8'h0c;
	localparam logic [7:0] ADDR_RXDATA  = 8'h10;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int ST_MP_TX   = 0;
	localparam int ST_MP_RX   = 1;
	localparam int ST_TX_DONE = 2;
	localparam int ST_PARITY  = 3;
	localparam int ST_ERR_SIG = 4;

	// ----------------------------------------------------------------
	// Control register fields and reset value
	// ----------------------------------------------------------------
	localparam int CT_CARD_MODE = 0;
	localparam int CT_TX_EN     = 1;
	localparam int CT_RX_EN     = 2;
	localparam int CT_GUARD     = 3;
	localparam int CT_BLOCK     = 4;
	localparam int CT_WIDTH     = 5;
	localparam logic [4:0] CT_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Interrupt status and mask fields
	// ----------------------------------------------------------------
	localparam int IRQ_PARITY  = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_ERR_SIG = 2;
	localparam int IRQ_WIDTH   = 3;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// ----------------------------------------------------------------
	// Transmit done delay in half-etu ticks
	// ----------------------------------------------------------------
	localparam logic [2:0] HALF_ETU_NORMAL = 3'h5;	// 2.5 etu
	localparam logic [2:0] HALF_ETU_BLOCK  = 3'h3;	// 1.5 etu
	localparam logic [2:0] HALF_ETU_GUARD  = 3'h2;	// 1.0 etu

	// ----------------------------------------------------------------
	// Reset values of data and flags
	// ----------------------------------------------------------------
	localparam logic       TX_DONE_RESET = 1'b1;
	localparam logic       FLAG_RESET    = 1'b0;
	localparam logic [7:0] RXDATA_RESET  = 8'h00;
	localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

	// ----------------------------------------------------------------
	// State structs
	// ----------------------------------------------------------------
	typedef struct packed {
		logic flag;
		logic armed;
	} scsf_flag_t;

	typedef struct packed {
		logic [2:0] count;
		logic       busy;
		logic       expire;
	} scsf_timer_t;

	typedef struct packed {
		logic [7:0]  rxData;
		logic [4:0]  ctrl;
		logic        mpTx;
		logic [2:0]  irqStat;
		logic [2:0]  irqMask;
		logic        irq;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        rxLoad;
		logic        rxSetFull;
		logic        txHalt;
	} scsf_top_t;

endpackage

// >>> hw/scsf_clear_flag.sv
// Status flag that software clears by reading 1 and then writing 0
`timescale 1ns/1ps
module scsf_clear_flag import scsf_pkg::*; #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Hardware set and extra clear
	input  wire logic setIn,
	input  wire logic hwClear,
	// Bus side
	input  wire logic readSeen,
	input  wire logic writeZero,
	// Flag value
	output logic      flagOut
);

	scsf_flag_t state_reg;
	scsf_flag_t state_next;

	// Arming remembers a read of 1, so a blind write of 0 cannot clear an unseen event
	always_comb begin
		state_next = state_reg;
		if (readSeen && state_reg.flag) begin
			state_next.armed = 1'b1;
		end
		if ((writeZero && state_reg.armed) || hwClear) begin
			state_next.flag  = 1'b0;
			state_next.armed = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (setIn) begin
			state_next.flag = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{flag: RESET_VAL, armed: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign flagOut = state_reg.flag;

endmodule // scsf_clear_flag

// >>> hw/scsf_etu_timer.sv
// Half-etu down counter that pulses once when the loaded delay runs out
`timescale 1ns/1ps
module scsf_etu_timer import scsf_pkg::*; (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rstn,
	// Control
	input  wire logic       load,
	input  wire logic [2:0] loadCount,
	input  wire logic       halfTick,
	// Result
	output logic            expire
);

	scsf_timer_t state_reg;
	scsf_timer_t state_next;

	always_comb begin
		state_next        = state_reg;
		state_next.expire = 1'b0;
		if (load) begin
			state_next.count = loadCount;
			state_next.busy  = 1'b1;
		end else if (state_reg.busy && halfTick) begin
			if (state_reg.count == 3'h1) begin
				state_next.busy   = 1'b0;
				state_next.expire = 1'b1;
			end else begin
				state_next.count = state_reg.count - 3'h1;
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{count: 3'h0, busy: 1'b0, expire: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign expire = state_reg.expire;

endmodule // scsf_etu_timer

// >>> hw/scsf_status_flags.sv
// Smart card status flags with APB register access and interrupt
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
module scsf_status_flags import scsf_pkg::*; (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Receive engine
	input  wire logic        rxCharDone,
	input  wire logic [7:0]  rxChar,
	input  wire logic        rxParityOk,
	output logic             rxLoad,
	output logic             rxSetFull,
	output logic             rxHold,
	// Transmit engine
	input  wire logic        syncMode,
	input  wire logic        txStart,
	input  wire logic        txFrameEnd,
	input  wire logic        txHolderEmpty,
	input  wire logic        dmaTxWrite,
	output logic             txHalt,
	output logic             txDone,
	// Baud generator and card line
	input  wire logic        halfEtuTick,
	input  wire logic        errSample,
	input  wire logic        errLineIn,
	// Mode and interrupt
	output logic             cardMode,
	output logic             irq
);

	// ----------------------------------------------------------------
	// State and bus decode
	// ----------------------------------------------------------------
	scsf_top_t state_reg;
	scsf_top_t state_next;

	logic       accessDone;
	logic       wrDone;
	logic       rdDone;
	logic       statusWr;
	logic       statusRd;
	logic       parityFlag;
	logic       txDoneFlag;
	logic       errSeenFlag;
	logic       paritySet;
	logic       errSet;
	logic       txDoneSet;
	logic       txDoneTimed;
	logic       timerExpire;
	logic       timerLoad;
	logic [2:0] timerCount;
	logic       rxAccept;
	logic [2:0] irqEvents;

	// A transfer completes at the edge where the access phase sees pready
	assign accessDone = psel && penable && state_reg.pready;
	assign wrDone     = accessDone && pwrite;
	assign rdDone     = accessDone && !pwrite;
	assign statusWr   = wrDone && (paddr == ADDR_STATUS);
	assign statusRd   = rdDone && (paddr == ADDR_STATUS);

	// ----------------------------------------------------------------
	// Flag set conditions
	// ----------------------------------------------------------------
	// refuse reception
	assign rxAccept  = rxCharDone && !parityFlag;
	assign paritySet = rxAccept && !rxParityOk;
	assign errSet    = errSample && !errLineIn && state_reg.ctrl[CT_CARD_MODE];

	assign timerLoad  = txStart && state_reg.ctrl[CT_CARD_MODE];
	assign timerCount = state_reg.ctrl[CT_GUARD] ? HALF_ETU_GUARD :
		(state_reg.ctrl[CT_BLOCK] ? HALF_ETU_BLOCK : HALF_ETU_NORMAL);

	// Outside card mode the guard timing does not apply; frame end from the shifter sets it
	assign txDoneTimed = (timerExpire && state_reg.ctrl[CT_CARD_MODE] && !errSeenFlag && txHolderEmpty)
		|| (txFrameEnd && !state_reg.ctrl[CT_CARD_MODE] && txHolderEmpty);
	assign txDoneSet = (!state_reg.ctrl[CT_TX_EN] && !errSeenFlag) || txDoneTimed;

	assign irqEvents = {errSet, txDoneTimed, paritySet};

	// ----------------------------------------------------------------
	// Flags and etu timer
	// ----------------------------------------------------------------
	// only zero clears
	scsf_clear_flag #(
		.RESET_VAL (FLAG_RESET)
	) u_parity_flag (
		.clk       (clk),
		.rstn      (rstn),
		.setIn     (paritySet),
		.hwClear   (1'b0),
		.readSeen  (statusRd),
		.writeZero (statusWr && !pwdata[ST_PARITY]),
		.flagOut   (parityFlag)
	);

	scsf_clear_flag #(
		.RESET_VAL (TX_DONE_RESET)
	) u_tx_done_flag (
		.clk       (clk),
		.rstn      (rstn),
		.setIn     (txDoneSet),
		.hwClear   (dmaTxWrite),
		.readSeen  (statusRd),
		.writeZero (statusWr && !pwdata[ST_TX_DONE]),
		.flagOut   (txDoneFlag)
	);

	// Error signal seen, cleared the same way
	scsf_clear_flag #(
		.RESET_VAL (FLAG_RESET)
	) u_err_seen_flag (
		.clk       (clk),
		.rstn      (rstn),
		.setIn     (errSet),
		.hwClear   (1'b0),
		.readSeen  (statusRd),
		.writeZero (statusWr && !pwdata[ST_ERR_SIG]),
		.flagOut   (errSeenFlag)
	);

	// Delay from transmit start to transmit done
	scsf_etu_timer u_etu_timer (
		.clk       (clk),
		.rstn      (rstn),
		.load      (timerLoad),
		.loadCount (timerCount),
		.halfTick  (halfEtuTick),
		.expire    (timerExpire)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next           = state_reg;
		state_next.rxLoad    = 1'b0;
		state_next.rxSetFull = 1'b0;

		if (rxAccept) begin
			state_next.rxData    = rxChar;
			state_next.rxLoad    = 1'b1;
			state_next.rxSetFull = rxParityOk;
		end

		state_next.txHalt = syncMode && (parityFlag || paritySet);

		// Register writes at the completing edge
		if (wrDone) begin
			unique case (paddr)
				ADDR_STATUS: begin
					state_next.mpTx = pwdata[ST_MP_TX];
				end
				ADDR_CONTROL: begin
					state_next.ctrl = pwdata[CT_WIDTH-1:0];
				end
				ADDR_IRQMASK: begin
					state_next.irqMask = pwdata[IRQ_WIDTH-1:0];
				end
				ADDR_IRQSTAT: begin
					state_next.irqStat = state_reg.irqStat & ~pwdata[IRQ_WIDTH-1:0];
				end
				default: begin
					state_next.ctrl = state_reg.ctrl;
				end
			endcase
		end

		// Events win over a write-one clear in the same cycle
		state_next.irqStat = state_next.irqStat | irqEvents;
		state_next.irq     = |(state_next.irqStat & state_next.irqMask);

		// Answer one cycle after setup; ready drops after the access edge
		state_next.pready  = 1'b0;
		state_next.pslverr = 1'b0;
		state_next.prdata  = RDATA_ZERO;
		if (psel && !penable) begin
			state_next.pready = 1'b1;
			unique case (paddr)
				ADDR_STATUS: begin
					state_next.prdata[ST_MP_RX]   = 1'b0;
					state_next.prdata[ST_MP_TX]   = state_reg.mpTx;
					state_next.prdata[ST_TX_DONE] = txDoneFlag;
					state_next.prdata[ST_PARITY]  = parityFlag;
					state_next.prdata[ST_ERR_SIG] = errSeenFlag;
				end
				ADDR_CONTROL: begin
					state_next.prdata[CT_WIDTH-1:0] = state_reg.ctrl;
				end
				ADDR_IRQSTAT: begin
					state_next.prdata[IRQ_WIDTH-1:0] = state_reg.irqStat;
				end
				ADDR_IRQMASK: begin
					state_next.prdata[IRQ_WIDTH-1:0] = state_reg.irqMask;
				end
				ADDR_RXDATA: begin
					state_next.prdata[7:0] = state_reg.rxData;
				end
				default: begin
					state_next.pslverr = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '{
				rxData:    RXDATA_RESET,
				ctrl:      CT_RESET,
				mpTx:      1'b0,
				irqStat:   IRQ_RESET,
				irqMask:   IRQ_RESET,
				irq:       1'b0,
				pready:    1'b0,
				pslverr:   1'b0,
				prdata:    RDATA_ZERO,
				rxLoad:    1'b0,
				rxSetFull: 1'b0,
				txHalt:    1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign prdata    = state_reg.prdata;
	assign pready    = state_reg.pready;
	assign pslverr   = state_reg.pslverr;
	assign rxLoad    = state_reg.rxLoad;
	assign rxSetFull = state_reg.rxSetFull;
	assign txHalt    = state_reg.txHalt;
	assign cardMode  = state_reg.ctrl[CT_CARD_MODE];
	assign irq       = state_reg.irq;
	// Hold reception while parity fault stands
	assign rxHold    = parityFlag;
	assign txDone    = txDoneFlag;

endmodule // scsf_status_flags

// >>> bench/scsf_status_flags_sva.sv
// Concurrent checks on the ports of the smart card status flags block
`timescale 1ns/1ps
module scsf_status_flags_sva import scsf_pkg::*; (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// APB slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Receive engine
	input wire logic        rxCharDone,
	input wire logic [7:0]  rxChar,
	input wire logic        rxParityOk,
	input wire logic        rxLoad,
	input wire logic        rxSetFull,
	input wire logic        rxHold,
	// Transmit engine
	input wire logic        syncMode,
	input wire logic        txStart,
	input wire logic        txFrameEnd,
	input wire logic        txHolderEmpty,
	input wire logic        dmaTxWrite,
	input wire logic        txHalt,
	input wire logic        txDone,
	// Baud generator, card line, mode and interrupt
	input wire logic        halfEtuTick,
	input wire logic        errSample,
	input wire logic        errLineIn,
	input wire logic        cardMode,
	input wire logic        irq
);
	// Status write in its access phase, the only thing that may clear the parity flag
	wire logic wrSt = psel && penable && pwrite && paddr == ADDR_STATUS;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------------------------------
	// Bus timing
	// ----------------------------------------------------------------
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
	a_idle_rdata: assert property (!pready |-> prdata == RDATA_ZERO) else $error("read data outside access");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");

	// ----------------------------------------------------------------
	// Receive and flag behaviour
	// ----------------------------------------------------------------
	a_rx_char_loads: assert property (rxCharDone && !rxHold |=> rxLoad)
		else $error("character not loaded");
	a_parity_no_full: assert property (rxCharDone && !rxHold && !rxParityOk |=> !rxSetFull ##[0:1] rxHold)
		else $error("bad parity handled wrongly");
	a_hold_refuses_rx: assert property (rxHold && rxCharDone |=> !rxLoad && !rxSetFull)
		else $error("reception while held");
	a_hold_keeps: assert property (rxHold && !wrSt && !$past(wrSt) |=> rxHold)
		else $error("parity flag lost without write");
	a_halt_in_sync: assert property (rxHold && syncMode ##1 rxHold && syncMode |-> txHalt)
		else $error("transmit not halted");
	a_mode_by_write: assert property ($changed(cardMode) |-> $past(wrSt || (psel && penable && pwrite && paddr == ADDR_CONTROL)))
		else $error("mode changed without write");
endmodule // scsf_status_flags_sva

bind scsf_status_flags scsf_status_flags_sva i_scsf_status_flags_sva (.*);

// >>> bench/scsf_card_model.sv
// Behavioural smart card that can answer with a low error signal
`timescale 1ns/1ps
module scsf_card_model (
	// Clock
	input  wire logic clk,
	// Error request from the bench
	input  wire logic errReq,
	// Card line, pulled up while released
	output logic      errLine
);
	// Line only goes low while the card reports a bad character
	initial errLine = 1'b1;
	always @(posedge clk) begin
		errLine <= !errReq;
	end
endmodule // scsf_card_model

// >>> bench/tb.sv
// Self-checking bench for the smart card status flags block
`timescale 1ns/1ps
module tb import scsf_pkg::*;;
	logic        clk, rstn, psel, penable, pwrite, rxParityOk, syncMode, txHolderEmpty, errReq, err;
	logic        txFrameEnd, rxLoad, rxSetFull, rxHold, txHalt, txDone, cardMode, irq, pready, pslverr;
	wire logic   errLineIn;
	logic [4:0]  pul;
	logic [7:0]  paddr, rxChar;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0]  cfg [4] = '{5'h07, 5'h17, 5'h0f, 5'h1f};
	int          half [4] = '{5, 3, 2, 2};
	int          failures, tests_run, cycles;

	scsf_status_flags i_scsf_status_flags (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rxCharDone(pul[4]), .rxChar(rxChar), .rxParityOk(rxParityOk), .rxLoad(rxLoad), .rxSetFull(rxSetFull),
		.rxHold(rxHold), .syncMode(syncMode), .txStart(pul[0]), .txFrameEnd(txFrameEnd),
		.txHolderEmpty(txHolderEmpty), .dmaTxWrite(pul[1]), .txHalt(txHalt), .txDone(txDone),
		.halfEtuTick(pul[2]), .errSample(pul[3]), .errLineIn(errLineIn), .cardMode(cardMode), .irq(irq));
	scsf_card_model i_scsf_card_model (.clk(clk), .errReq(errReq), .errLine(errLineIn));

	// Clock and hang guard; the run needs well under a thousand cycles
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer, entered right after a rising edge
	// An idle edge follows the release, so a following setup never drives psel twice in one step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	// One-cycle pulses: b0 start, b1 dma write, b2 half tick, b3 error sample, b4 char done
	task automatic pulse(input logic [4:0] m);
		pul <= m;
		@(posedge clk);
		pul <= 5'h00;
		@(posedge clk);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			pulse(5'h04);
			@(posedge clk);
		end
	endtask

	initial begin
		{rstn, psel, penable, pwrite, rxParityOk, syncMode, txFrameEnd, errReq} = 8'h00;
		{paddr, rxChar, pwdata, pul} = 53'h0;
		txHolderEmpty = 1'b1;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		for (int i = 0; i < 5; i++) rdc(8'(4 * i), i == 0 ? 32'h04 : 32'h00);
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("reset and map test done");
		// Transmit done timing per guard and block setting
		foreach (cfg[i]) begin
			apb(1'b1, ADDR_CONTROL, {27'h0, cfg[i]});
			chk(32'(cardMode), 32'h1);
			apb(1'b0, ADDR_STATUS, 32'h0);
			apb(1'b1, ADDR_STATUS, 32'h1c);
			rdc(ADDR_STATUS, 32'h04);
			apb(1'b1, ADDR_STATUS, 32'h0);
			rdc(ADDR_STATUS, 32'h00);
			pulse(5'h01);
			ticks(half[i] - 1);
			@(posedge clk);
			chk(32'(txDone), 32'h0);
			ticks(1);
			@(posedge clk);
			chk(32'(txDone), 32'h1);
		end
		pulse(5'h02);
		@(posedge clk);
		chk(32'(txDone), 32'h0);
		$display("transmit done test done");
		// Good character, then a parity fault that holds reception
		rxChar <= 8'h5a;
		rxParityOk <= 1'b1;
		pulse(5'h10);
		chk(32'({rxLoad, rxSetFull}), 32'h3);
		rdc(ADDR_RXDATA, 32'h5a);
		rxChar <= 8'ha5;
		rxParityOk <= 1'b0;
		pulse(5'h10);
		chk(32'({rxLoad, rxSetFull}), 32'h2);
		@(posedge clk);
		chk(32'(rxHold), 32'h1);
		apb(1'b1, ADDR_STATUS, 32'h0);
		apb(1'b1, ADDR_CONTROL, 32'h03);
		@(posedge clk);
		chk(32'(rxHold), 32'h1);
		syncMode <= 1'b1;
		rxChar <= 8'h33;
		rxParityOk <= 1'b1;
		pulse(5'h10);
		chk(32'({rxLoad, rxSetFull, txHalt}), 32'h1);
		rdc(ADDR_RXDATA, 32'ha5);
		rdc(ADDR_STATUS, 32'h08);
		apb(1'b1, ADDR_STATUS, 32'h0);
		rdc(ADDR_STATUS, 32'h00);
		syncMode <= 1'b0;
		$display("parity test done");
		// Error signal from the card, interrupt mask and blocked transmit done
		apb(1'b1, ADDR_IRQSTAT, 32'h3);
		rdc(ADDR_IRQSTAT, 32'h0);
		errReq <= 1'b1;
		repeat (2) @(posedge clk);
		pulse(5'h08);
		errReq <= 1'b0;
		rdc(ADDR_STATUS, 32'h10);
		chk(32'(irq), 32'h0);
		apb(1'b1, ADDR_IRQMASK, 32'h4);
		repeat (2) @(posedge clk);
		chk(32'(irq), 32'h1);
		rdc(ADDR_IRQSTAT, 32'h4);
		pulse(5'h01);
		ticks(5);
		@(posedge clk);
		chk(32'(txDone), 32'h0);
		apb(1'b1, ADDR_STATUS, 32'h0);
		apb(1'b1, ADDR_IRQSTAT, 32'h4);
		apb(1'b1, ADDR_CONTROL, 32'h01);
		repeat (2) @(posedge clk);
		chk(32'({irq, txDone}), 32'h1);
		// Outside card mode the frame end, not the guard timer, sets transmit done
		apb(1'b1, ADDR_CONTROL, 32'h02);
		chk(32'(cardMode), 32'h0);
		rdc(ADDR_STATUS, 32'h04);
		apb(1'b1, ADDR_STATUS, 32'h0);
		rdc(ADDR_STATUS, 32'h00);
		txFrameEnd <= 1'b1;
		@(posedge clk);
		txFrameEnd <= 1'b0;
		@(posedge clk);
		chk(32'(txDone), 32'h1);
		$display("error signal test done");
		end_sim();
	end
endmodule // tb
